/* File: mpcw_asserts.sv */
// Port checks for the multi-pin configuration writer
`timescale 1ns/1ps
module mpcw_asserts #(
  parameter int NUM_GROUPS = 2,
  parameter int ADDR_W = 8,
  localparam int NP = NUM_GROUPS * mpcw_pkg::MPCW_GROUP_PINS
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [NP-1:0] pin_dir_o,
  input wire logic [NP*mpcw_pkg::MPCW_FUNC_W-1:0] pin_function_register_o,
  input wire logic [NP-1:0] drive_strength_select_o,
  input wire logic [NP-1:0] pull_resistor_enable_o,
  input wire logic [NP-1:0] input_buffer_enable_o,
  input wire logic [NP-1:0] peripheral_select_enable_o
);
  import mpcw_pkg::*;
  // ----------------------------------------
  // Accepted multi-pin writes
  // ----------------------------------------
  wire mw = avs_write_i && !avs_waitrequest_o && avs_byteenable_i == 4'hf && avs_address_i[6:0] == MPCW_OFF_MULTI;
  logic mw_q;
  logic [31:0] wd_q;
  logic [6:0] p0_q;
  always_ff @(posedge mclk_i) begin
    mw_q <= mw;
    wd_q <= avs_writedata_i;
    p0_q <= 7'({avs_address_i[ADDR_W-1:7], avs_writedata_i[31], 4'h0});
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  chk_mux_load: assert property (mw_q && wd_q[28] && wd_q[0] && wd_q[15] |->
    pin_function_register_o[p0_q*4 +: 4] == wd_q[27:24] && pin_function_register_o[p0_q*4+60 +: 4] == wd_q[27:24])
    else $error("function code not loaded");
  chk_mux_skip: assert property (mw_q && !wd_q[28] |-> $stable(pin_function_register_o))
    else $error("function changed without trigger");
  chk_drv_copy: assert property (mw_q && wd_q[30] && wd_q[15] |-> drive_strength_select_o[p0_q+15] == wd_q[22])
    else $error("drive strength wrong");
  chk_pull_copy: assert property (mw_q && wd_q[30] && wd_q[0] |-> pull_resistor_enable_o[p0_q] == wd_q[18])
    else $error("pull enable wrong");
  chk_inbuf_copy: assert property (mw_q && wd_q[30] && wd_q[15] |-> input_buffer_enable_o[p0_q+15] == wd_q[17])
    else $error("input buffer enable wrong");
  chk_psel_copy: assert property (mw_q && wd_q[30] && wd_q[0] |-> peripheral_select_enable_o[p0_q] == wd_q[16])
    else $error("peripheral select wrong");
  chk_mask_keep: assert property (mw && avs_writedata_i[15:0] == 16'h0000 |=>
    $stable({drive_strength_select_o, pull_resistor_enable_o, input_buffer_enable_o, peripheral_select_enable_o}))
    else $error("unmasked write changed pins");
  chk_half_apart: assert property (mw && !avs_writedata_i[31] && !avs_address_i[7] |=>
    $stable(drive_strength_select_o[31:16])) else $error("other half changed");
  chk_group_apart: assert property (mw && !avs_address_i[7] |=> $stable(pin_function_register_o[NP*4-1:128]))
    else $error("other group changed");
  chk_read_zero: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[6:0] == MPCW_OFF_MULTI |->
    avs_readdata_o == 32'h0000_0000) else $error("multi-pin read not zero");
endmodule

/* File: mpcw_pin_cell.sv */
// Storage of one pin: direction, function code and configuration bits
`timescale 1ns/1ps
module mpcw_pin_cell (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic dir_we_i,
  input wire logic dir_i,
  input wire logic func_we_i,
  input wire logic [mpcw_pkg::MPCW_FUNC_W-1:0] func_i,
  input wire logic cfg_we_i,
  input wire logic drv_i,
  input wire logic pull_i,
  input wire logic inbuf_i,
  input wire logic psel_i,
  output logic dir_o,
  output logic [mpcw_pkg::MPCW_FUNC_W-1:0] func_o,
  output logic drv_o,
  output logic pull_o,
  output logic inbuf_o,
  output logic psel_o
);
  import mpcw_pkg::*;

  // ------------------------------------------------------------
  // Pin registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      dir_o <= MPCW_RST_DIR;
      func_o <= MPCW_RST_FUNC;
      drv_o <= MPCW_RST_CFG;
      pull_o <= MPCW_RST_CFG;
      inbuf_o <= MPCW_RST_CFG;
      psel_o <= MPCW_RST_CFG;
    end else begin
      if (dir_we_i) begin
        dir_o <= dir_i;
      end
      if (func_we_i) begin
        func_o <= func_i;
      end
      if (cfg_we_i) begin
        drv_o <= drv_i;
        pull_o <= pull_i;
        inbuf_o <= inbuf_i;
        psel_o <= psel_i;
      end
    end
  end

endmodule

/* File: mpcw_pkg.sv */
// Constants and helpers shared by the multi-pin configuration writer
package mpcw_pkg;

  // ------------------------------------------------------------
  // Group geometry
  // ------------------------------------------------------------
  localparam int MPCW_GROUP_PINS = 32;
  localparam int MPCW_HALF_PINS = 16;
  localparam int MPCW_FUNC_W = 4;
  localparam int MPCW_CFG_BYTE_W = 8;
  localparam int MPCW_GROUP_ADDR_LSB = 7;

  // ------------------------------------------------------------
  // Offsets inside one group
  // ------------------------------------------------------------
  localparam logic [6:0] MPCW_OFF_DIR = 7'h00;
  localparam logic [6:0] MPCW_OFF_MULTI = 7'h28;
  localparam logic [6:0] MPCW_OFF_FUNC = 7'h30;
  localparam logic [6:0] MPCW_OFF_CFG = 7'h40;

  // ------------------------------------------------------------
  // Fields of the multi-pin configuration write
  // ------------------------------------------------------------
  localparam int MPCW_HALF_SEL_BIT = 31;
  localparam int MPCW_CFG_TRIG_BIT = 30;
  localparam int MPCW_MUX_TRIG_BIT = 28;
  localparam int MPCW_FUNC_LSB = 24;
  localparam int MPCW_DRV_BIT = 22;
  localparam int MPCW_PULL_BIT = 18;
  localparam int MPCW_INBUF_BIT = 17;
  localparam int MPCW_PSEL_BIT = 16;
  localparam int MPCW_MASK_LSB = 0;

  // ------------------------------------------------------------
  // Fields of one pin configuration byte
  // ------------------------------------------------------------
  localparam int MPCW_CFGB_PSEL = 0;
  localparam int MPCW_CFGB_INBUF = 1;
  localparam int MPCW_CFGB_PULL = 2;
  localparam int MPCW_CFGB_DRV = 6;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic MPCW_RST_DIR = 1'b0;
  localparam logic [3:0] MPCW_RST_FUNC = 4'h0;
  localparam logic MPCW_RST_CFG = 1'b0;
  localparam logic [31:0] MPCW_READ_ZERO = 32'h0000_0000;

  // Packs one pin's configuration bits into its byte
  function automatic logic [7:0] mpcw_cfg_pack(input logic drv, input logic pull, input logic inbuf,
                                               input logic psel);
    logic [7:0] b;
    b = 8'h00;
    b[MPCW_CFGB_DRV] = drv;
    b[MPCW_CFGB_PULL] = pull;
    b[MPCW_CFGB_INBUF] = inbuf;
    b[MPCW_CFGB_PSEL] = psel;
    return b;
  endfunction

endpackage

/* File: mpcw_tb.sv */
// Self-checking bench for the multi-pin configuration writer
`timescale 1ns/1ps
bind mpcw_top mpcw_asserts #(.NUM_GROUPS(NUM_GROUPS), .ADDR_W(ADDR_W)) mpcw_asserts_inst (.mclk_i, .srst_i,
  .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
  .avs_waitrequest_o, .pin_dir_o, .pin_function_register_o, .drive_strength_select_o, .pull_resistor_enable_o,
  .input_buffer_enable_o, .peripheral_select_enable_o);
module tb;
  import mpcw_pkg::*;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o, rd;
  logic avs_waitrequest_o;
  logic [63:0] pin_dir_o, drive_strength_select_o, pull_resistor_enable_o, input_buffer_enable_o;
  logic [63:0] peripheral_select_enable_o, e_dir, e_drv, e_pull, e_inb, e_psel;
  logic [255:0] pin_function_register_o, e_func;
  int bad_count = 0;
  int n_tests = 0;
  always #20 mclk_i = ~mclk_i;
  mpcw_top #(.NUM_GROUPS(2), .ADDR_W(8)) mpcw_top_inst (.mclk_i, .srst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .pin_dir_o,
    .pin_function_register_o, .drive_strength_select_o, .pull_resistor_enable_o, .input_buffer_enable_o,
    .peripheral_select_enable_o);
  // ----------------------------------------
  // Expectations, bus cycles and compares
  // ----------------------------------------
  task model(input logic [7:0] a, input logic [31:0] d);
    int p;
    if (a[6:0] == MPCW_OFF_DIR) e_dir[a[7]*32 +: 32] = d;
    if (a[6:4] == 3'h3) e_func[a[7]*128 + a[3:2]*32 +: 32] = d;
    if (a[6:5] == 2'h2) for (int i = 0; i < 4; i++) begin
      p = a[7]*32 + a[4:2]*4 + i;
      {e_drv[p], e_pull[p], e_inb[p], e_psel[p]} = {d[i*8+6], d[i*8+2], d[i*8+1], d[i*8]};
    end
    if (a[6:0] == MPCW_OFF_MULTI) for (int i = 0; i < 16; i++) if (d[i]) begin
      p = a[7]*32 + d[31]*16 + i;
      if (d[28]) e_func[p*4 +: 4] = d[27:24];
      if (d[30]) {e_drv[p], e_pull[p], e_inb[p], e_psel[p]} = {d[22], d[18], d[17], d[16]};
    end
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic w;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge mclk_i);
      w = avs_waitrequest_o;
      rd = avs_readdata_o;
    end while (w !== 1'b0);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (wr && be == 4'hf) model(a, d);
  endtask
  task cmp_vec(input logic [255:0] got, input logic [255:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: pins %h not %h", $time, got, exp);
    end
  endtask
  task cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: read %h not %h", $time, got, exp);
    end
  endtask
  task chk_pins;
    @(negedge mclk_i);
    cmp_vec(pin_function_register_o, e_func);
    cmp_vec(256'({pin_dir_o, drive_strength_select_o, pull_resistor_enable_o}), 256'({e_dir, e_drv, e_pull}));
    cmp_vec(256'({input_buffer_enable_o, peripheral_select_enable_o}), 256'({e_inb, e_psel}));
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_mux;
    bus(1'b1, 8'h28, 32'h1a00_8001, 4'hf);
    chk_pins();
    bus(1'b1, 8'h28, 32'h8500_ffff, 4'hf);
    chk_pins();
    bus(1'b1, 8'ha8, 32'h9300_0010, 4'hf);
    chk_pins();
    $display("test mux done");
  endtask
  task t_cfg;
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 8'ha8, 32'hc000_ffff | (32'h1 << (k == 0 ? 22 : 19 - k)), 4'hf);
      chk_pins();
    end
    bus(1'b1, 8'h28, 32'h5f47_00f0, 4'hf);
    chk_pins();
    $display("test cfg done");
  endtask
  task t_refuse;
    bus(1'b1, 8'h28, 32'h5f47_ffff, 4'h7);
    chk_pins();
    bus(1'b1, 8'h28, 32'h5f47_0000, 4'hf);
    chk_pins();
    bus(1'b0, 8'h28, 32'h0, 4'hf);
    cmp_word(rd, 32'h0000_0000);
    bus(1'b0, 8'h7c, 32'h0, 4'hf);
    cmp_word(rd, 32'h0000_0000);
    $display("test refuse done");
  endtask
  task t_direct;
    bus(1'b0, 8'h30, 32'h0, 4'hf);
    cmp_word(rd, 32'hffff_000a);
    bus(1'b0, 8'h44, 32'h0, 4'hf);
    cmp_word(rd, 32'h4747_4747);
    bus(1'b1, 8'h3c, 32'h1234_5678, 4'hf);
    bus(1'b1, 8'hc4, 32'hffff_0146, 4'hf);
    chk_pins();
    bus(1'b0, 8'h3c, 32'h0, 4'hf);
    cmp_word(rd, 32'h1234_5678);
    bus(1'b0, 8'hc4, 32'h0, 4'hf);
    cmp_word(rd, 32'h4747_0146);
    $display("test direct done");
  endtask
  task t_dir;
    bus(1'b1, 8'h00, 32'h1234_5678, 4'hf);
    bus(1'b1, 8'h80, 32'h9abc_def0, 4'hf);
    chk_pins();
    bus(1'b0, 8'h80, 32'h0, 4'hf);
    cmp_word(rd, 32'h9abc_def0);
    srst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    srst_i <= 1'b0;
    {e_dir, e_drv, e_pull, e_inb, e_psel, e_func} = '0;
    chk_pins();
    $display("test dir done");
  endtask
  initial begin
    {e_dir, e_drv, e_pull, e_inb, e_psel, e_func} = '0;
    repeat (2) @(posedge mclk_i);
    srst_i <= 1'b0;
    chk_pins();
    t_mux();
    t_cfg();
    t_refuse();
    t_direct();
    t_dir();
    results();
  end
  initial begin
    #100000;
    bad_count++;
    results();
  end
endmodule

/* File: mpcw_top.sv */
// Pin controller register port with the multi-pin configuration write
//
// Function
// - Mux trigger set updates selected pins' function registers; clear leaves them.
// - Mux trigger loads bits 27:24 into each selected pin's function register.
// - Config trigger copies bit 22 into each selected pin's drive strength.
// - Config trigger copies bit 18 into each selected pin's pull enable.
// - Config trigger copies bit 17 into each selected pin's input buffer enable.
// - Config trigger copies bit 16 into each selected pin's peripheral select enable.
// - Mask bits 15:0 pick pins inside the half-word chosen by half select.
// - Mask bit zero keeps a pin unchanged; mask bit one updates it.
// - Reading the multi-pin configuration register always returns zero.
// - Pins form groups of exactly 32, each with its own register set.
// - First group at base with direction at 0x00; next group at 0x80.
//
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module mpcw_top #(
  parameter int NUM_GROUPS = 2,
  parameter int ADDR_W = 8
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [NUM_GROUPS*mpcw_pkg::MPCW_GROUP_PINS-1:0] pin_dir_o,
  output logic [NUM_GROUPS*mpcw_pkg::MPCW_GROUP_PINS*mpcw_pkg::MPCW_FUNC_W-1:0] pin_function_register_o,
  output logic [NUM_GROUPS*mpcw_pkg::MPCW_GROUP_PINS-1:0] drive_strength_select_o,
  output logic [NUM_GROUPS*mpcw_pkg::MPCW_GROUP_PINS-1:0] pull_resistor_enable_o,
  output logic [NUM_GROUPS*mpcw_pkg::MPCW_GROUP_PINS-1:0] input_buffer_enable_o,
  output logic [NUM_GROUPS*mpcw_pkg::MPCW_GROUP_PINS-1:0] peripheral_select_enable_o
);
  import mpcw_pkg::*;

  localparam int NPINS = NUM_GROUPS * MPCW_GROUP_PINS;
  localparam int GRP_W = ADDR_W - MPCW_GROUP_ADDR_LSB;

  // ------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------
  logic ack_q;
  logic ack_d;
  logic [31:0] readdata_q;
  logic [31:0] rd_word;
  wire req = avs_read_i | avs_write_i;
  wire wr_fire = avs_write_i & ack_q;
  wire rd_take = avs_read_i & ~ack_q;

  assign ack_d = req & ~ack_q;
  assign avs_waitrequest_o = req & ~ack_q;
  assign avs_readdata_o = readdata_q;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      readdata_q <= MPCW_READ_ZERO;
    end else if (rd_take) begin
      readdata_q <= rd_word;
    end
  end

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  wire [GRP_W-1:0] grp = avs_address_i[ADDR_W-1:MPCW_GROUP_ADDR_LSB];
  wire [6:0] off = avs_address_i[MPCW_GROUP_ADDR_LSB-1:0];
  wire grp_ok = (int'(grp) < NUM_GROUPS);
  wire word_ok = (off[1:0] == 2'b00);
  wire is_dir = word_ok & (off == MPCW_OFF_DIR);
  wire is_multi = word_ok & (off == MPCW_OFF_MULTI);
  wire is_func = word_ok & (off[6:4] == MPCW_OFF_FUNC[6:4]);
  wire is_cfg = word_ok & (off[6:5] == MPCW_OFF_CFG[6:5]);

  // Byte enables mask the write data; a disabled byte acts as zeros
  wire [31:0] be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                         {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire [31:0] wd = avs_writedata_i & be_mask;

  // ------------------------------------------------------------
  // Multi-pin write fields
  // ------------------------------------------------------------
  wire multi_fire = wr_fire & is_multi & grp_ok;
  wire half_sel = wd[MPCW_HALF_SEL_BIT];
  wire mux_trig = wd[MPCW_MUX_TRIG_BIT];
  wire cfg_trig = wd[MPCW_CFG_TRIG_BIT];
  wire [MPCW_FUNC_W-1:0] new_func = wd[MPCW_FUNC_LSB +: MPCW_FUNC_W];
  wire [MPCW_HALF_PINS-1:0] pin_mask = wd[MPCW_MASK_LSB +: MPCW_HALF_PINS];

  // ------------------------------------------------------------
  // Read-back vectors
  // ------------------------------------------------------------
  logic [NPINS*MPCW_CFG_BYTE_W-1:0] cfg_all;
  wire [GRP_W+6:0] func_base = {grp, off[3:2], 5'b00000};
  wire [GRP_W+7:0] cfg_base = {grp, off[4:2], 5'b00000};
  wire [GRP_W+4:0] dir_base = {grp, 5'b00000};
  wire [31:0] func_word = pin_function_register_o[func_base +: 32];
  wire [31:0] cfg_word = cfg_all[cfg_base +: 32];
  wire [31:0] dir_word = pin_dir_o[dir_base +: 32];

  // Multi-pin register and unmapped offsets read zero
  assign rd_word = !grp_ok ? MPCW_READ_ZERO :
                   is_dir ? dir_word :
                   is_func ? func_word :
                   is_cfg ? cfg_word :
                   MPCW_READ_ZERO;

  // ------------------------------------------------------------
  // Pin cells
  // ------------------------------------------------------------
  for (genvar p = 0; p < NPINS; p++) begin : g_pin
    localparam int G = p / MPCW_GROUP_PINS;
    localparam int L = p % MPCW_GROUP_PINS;
    localparam int FB = (L % 8) * MPCW_FUNC_W;
    localparam int CB = (L % 4) * MPCW_CFG_BYTE_W;
    logic grp_hit;
    logic multi_sel;
    logic func_direct;
    logic cfg_direct;
    logic dir_we;
    logic func_we;
    logic cfg_we;
    logic [MPCW_FUNC_W-1:0] func_val;
    logic drv_val;
    logic pull_val;
    logic inbuf_val;
    logic psel_val;

    // Each group decodes its own copy of the register set
    assign grp_hit = (grp == GRP_W'(G));
    // Pin chosen by half select and its mask bit
    assign multi_sel = multi_fire & grp_hit & (half_sel == 1'(L / MPCW_HALF_PINS))
                       & pin_mask[L % MPCW_HALF_PINS];
    assign func_direct = wr_fire & is_func & grp_hit & (off[3:2] == 2'(L / 8)) & avs_byteenable_i[(L % 8) / 2];
    assign cfg_direct = wr_fire & is_cfg & grp_hit & (off[4:2] == 3'(L / 4)) & avs_byteenable_i[L % 4];
    assign dir_we = wr_fire & is_dir & grp_hit & avs_byteenable_i[L / 8];
    // Trigger bits choose which registers the multi write touches
    assign func_we = (multi_sel & mux_trig) | func_direct;
    assign cfg_we = (multi_sel & cfg_trig) | cfg_direct;
    assign func_val = multi_sel ? new_func : wd[FB +: MPCW_FUNC_W];
    assign drv_val = multi_sel ? wd[MPCW_DRV_BIT] : wd[CB + MPCW_CFGB_DRV];
    assign pull_val = multi_sel ? wd[MPCW_PULL_BIT] : wd[CB + MPCW_CFGB_PULL];
    assign inbuf_val = multi_sel ? wd[MPCW_INBUF_BIT] : wd[CB + MPCW_CFGB_INBUF];
    assign psel_val = multi_sel ? wd[MPCW_PSEL_BIT] : wd[CB + MPCW_CFGB_PSEL];

    // All selected cells load on the same edge
    mpcw_pin_cell u_cell (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .dir_we_i(dir_we),
      .dir_i(wd[L]),
      .func_we_i(func_we),
      .func_i(func_val),
      .cfg_we_i(cfg_we),
      .drv_i(drv_val),
      .pull_i(pull_val),
      .inbuf_i(inbuf_val),
      .psel_i(psel_val),
      .dir_o(pin_dir_o[p]),
      .func_o(pin_function_register_o[p*MPCW_FUNC_W +: MPCW_FUNC_W]),
      .drv_o(drive_strength_select_o[p]),
      .pull_o(pull_resistor_enable_o[p]),
      .inbuf_o(input_buffer_enable_o[p]),
      .psel_o(peripheral_select_enable_o[p])
    );

    assign cfg_all[p*MPCW_CFG_BYTE_W +: MPCW_CFG_BYTE_W] =
      mpcw_cfg_pack(drive_strength_select_o[p], pull_resistor_enable_o[p],
                    input_buffer_enable_o[p], peripheral_select_enable_o[p]);
  end

endmodule
